//--- core/sba_alu.sv
// Subtract and subtract-with-borrow datapath with accumulators and flags.
// Assumes file and indirect operands are fetched by the core and presented
// with the instruction; results leave as a register write or memory write.
//
// What this block does
// - Accumulator subtract: named minus other, result to named accumulator.
// - Accumulator subtract works on all forty bits at once.
// - Decode fixed accumulator opcode; one selector bit, low bits zero.
// - Accumulator subtract changes only overflow and saturation flags.
// - File form: file minus default register minus inverted carry.
// - File form destination bit 0 to default register, 1 to file.
// - File form decoded by prefix, width bit, destination bit, 13-bit address.
// - Width bit 0 means word, 1 means byte, in every borrow form.
// - Default working register is register zero.
// - Zero flag is sticky: may be cleared, never set.
// - Borrow forms update nibble carry, negative, overflow, zero, carry.
// - Borrow is inverted carry flag.
// - Ten-bit literal form: register minus literal minus borrow, back in place.
// - Ten-bit literal form uses direct register addressing only.
// - Short literal form: base minus literal minus borrow to destination.
// - Short literal is five-bit unsigned, zero extended.
// - Base read directly; destination direct or indirect.
// - Register form: base minus source minus borrow to destination.
// - Source and destination support direct and indirect modes with updates.
// - Source and destination mode fields are independent.
// - One word, one cycle per instruction.
`timescale 1ns/1ns
`default_nettype none

module sba_alu (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [sba_pkg::INSN_W-1:0] insn,
  input wire logic [sba_pkg::WORD_W-1:0] file_data,
  input wire logic [sba_pkg::WORD_W-1:0] src_mem_data,
  input wire logic first_acc_clamp_enable,
  input wire logic second_acc_clamp_enable,
  input wire sba_pkg::sba_acc_load_t acc_load,
  output logic [sba_pkg::ACC_W-1:0] first_accumulator,
  output logic [sba_pkg::ACC_W-1:0] second_accumulator,
  output logic [sba_pkg::WORD_W*sba_pkg::REGS-1:0] reg_file,
  output sba_pkg::sba_flags_t flags,
  output sba_pkg::sba_mem_wr_t mem_wr,
  output logic illegal_op
);

  typedef struct packed {
    logic [sba_pkg::ACC_W-1:0] acc_a;
    logic [sba_pkg::ACC_W-1:0] acc_b;
    logic [sba_pkg::REGS-1:0][sba_pkg::WORD_W-1:0] regs;
    sba_pkg::sba_flags_t flags;
    sba_pkg::sba_mem_wr_t mem_wr;
    logic illegal;
  } sba_state_t;

  sba_state_t st_q;
  sba_state_t st_d;

  sba_pkg::sba_op_t op;
  logic byte_mode;
  logic borrow;
  logic [3:0] base_idx;
  logic [3:0] dst_idx;
  logic [3:0] src_idx;
  logic [2:0] dst_mode;
  logic [2:0] src_mode;
  logic five_bit_literal_form;
  logic [sba_pkg::WORD_W-1:0] opa;
  logic [sba_pkg::WORD_W-1:0] opb;
  logic [sba_pkg::WORD_W:0] diff;
  logic [4:0] nib_diff;
  logic [8:0] byte_diff;
  logic [sba_pkg::WORD_W-1:0] res;
  logic [sba_pkg::WORD_W-1:0] src_ptr;
  logic [sba_pkg::WORD_W-1:0] dst_ptr;
  logic [sba_pkg::WORD_W-1:0] step;
  logic [sba_pkg::ACC_W:0] acc_diff;
  logic [sba_pkg::ACC_W-1:0] acc_res;
  logic acc_ovf;
  logic acc_sat_ovf;
  logic acc_sat_en;
  logic acc_res_ovf;
  logic res_neg;
  logic res_zero;
  logic res_carry;
  logic res_ovf;

  // Decode of the opcode forms.
  always_comb
  begin
    op = sba_pkg::OP_NONE;
    if (insn_valid)
    begin
      if (insn[23:16] == sba_pkg::ACC_SUB_CODE[11:4] &&
          insn[14:12] == sba_pkg::ACC_SUB_CODE[2:0] &&
          insn[11:0] == 12'h000)
        op = sba_pkg::OP_ACC;
      else if (insn[23:15] == sba_pkg::FILE_FORM_CODE)
        op = sba_pkg::OP_FILE;
      else if (insn[23:15] == sba_pkg::TEN_BIT_LITERAL_FORM_CODE)
        op = sba_pkg::OP_TEN_BIT_LITERAL;
      else if (insn[23:19] == sba_pkg::REG_FORM_CODE)
        op = sba_pkg::OP_REG;
    end
  end

  assign byte_mode = insn[sba_pkg::BYTE_BIT];
  assign borrow = ~st_q.flags.carry_flag;
  assign base_idx = insn[sba_pkg::BASE_LSB +: 4];
  assign dst_idx = insn[sba_pkg::DREG_LSB +: 4];
  assign src_idx = insn[3:0];
  assign dst_mode = insn[sba_pkg::DMODE_LSB +: 3];
  assign src_mode = insn[sba_pkg::SMODE_LSB +: 3];
  assign five_bit_literal_form = (insn[sba_pkg::FIVE_BIT_LITERAL_MARK_LSB +: 2] == sba_pkg::FIVE_BIT_LITERAL_MARK);

  // Pointer step is one for bytes and two for words.
  assign step = byte_mode ? 16'h0001 : 16'h0002;
  assign src_ptr = st_q.regs[src_idx];
  assign dst_ptr = st_q.regs[dst_idx];

  // Operand selection for the borrow forms.
  always_comb
  begin
    opa = sba_pkg::WORD_ZERO;
    opb = sba_pkg::WORD_ZERO;
    case (op)
      sba_pkg::OP_FILE:
      begin
        opa = file_data;
        opb = st_q.regs[sba_pkg::DEFAULT_DEFAULT_WORKING_REGISTER_IDX];
      end
      sba_pkg::OP_TEN_BIT_LITERAL:
      begin
        opa = st_q.regs[src_idx];
        opb = {6'h00, insn[sba_pkg::TEN_BIT_LITERAL_LSB +: 10]};
      end
      sba_pkg::OP_REG:
      begin
        opa = st_q.regs[base_idx];
        if (five_bit_literal_form)
          opb = {11'h000, insn[4:0]};
        else if (src_mode == sba_pkg::AM_DIRECT)
          opb = st_q.regs[src_idx];
        else
          opb = src_mem_data;
      end
      default:
      begin
        opa = sba_pkg::WORD_ZERO;
        opb = sba_pkg::WORD_ZERO;
      end
    endcase
  end

  // Subtraction with borrow: a + ~b + carry, carry set means no borrow.
  assign diff = {1'b0, opa} + {1'b0, ~opb} +
                {16'h0000, st_q.flags.carry_flag};
  assign nib_diff = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} +
                    {4'h0, st_q.flags.carry_flag};
  assign byte_diff = {1'b0, opa[7:0]} + {1'b0, ~opb[7:0]} +
                     {8'h00, st_q.flags.carry_flag};
  assign res = diff[sba_pkg::WORD_W-1:0];

  // Byte mode takes its flags from the low byte.
  always_comb
  begin
    if (byte_mode)
    begin
      res_neg = res[7];
      res_zero = (res[7:0] == 8'h00);
      res_carry = byte_diff[8];
      res_ovf = (opa[7] ^ opb[7]) & (opa[7] ^ res[7]);
    end
    else
    begin
      res_neg = res[15];
      res_zero = (res == sba_pkg::WORD_ZERO);
      res_carry = diff[sba_pkg::WORD_W];
      res_ovf = (opa[15] ^ opb[15]) & (opa[15] ^ res[15]);
    end
  end

  // Forty-bit accumulator subtract; selector picks named accumulator.
  always_comb
  begin
    if (insn[sba_pkg::ACC_SEL_BIT])
      acc_diff = {st_q.acc_b[39], st_q.acc_b} -
                 {st_q.acc_a[39], st_q.acc_a};
    else
      acc_diff = {st_q.acc_a[39], st_q.acc_a} -
                 {st_q.acc_b[39], st_q.acc_b};
    acc_sat_en = insn[sba_pkg::ACC_SEL_BIT] ? second_acc_clamp_enable
                                            : first_acc_clamp_enable;
    // Overflow into guard bits: bits 39..31 not all equal.
    acc_ovf = ~((&acc_diff[39:31]) | ~(|acc_diff[39:31]));
    // True 40-bit overflow: sign extension bit disagrees.
    acc_sat_ovf = acc_diff[40] ^ acc_diff[39];
    acc_res = acc_diff[sba_pkg::ACC_W-1:0];
    if (acc_sat_en && (acc_ovf || acc_sat_ovf))
      acc_res = acc_diff[40] ? sba_pkg::ACC_MAX_NEG
                             : sba_pkg::ACC_MAX_POS;
    // The overflow flag describes the value written, so a clamp clears it.
    acc_res_ovf = ~((&acc_res[39:31]) | ~(|acc_res[39:31]));
  end

  // Next-state assembly.
  always_comb
  begin
    st_d = st_q;
    st_d.mem_wr = '0;
    st_d.illegal = insn_valid && (op == sba_pkg::OP_NONE);
    case (op)
      sba_pkg::OP_ACC:
      begin
        // Only accumulator flags change here.
        if (insn[sba_pkg::ACC_SEL_BIT])
        begin
          st_d.acc_b = acc_res;
          st_d.flags.second_acc_overflow_flag = acc_res_ovf;
          if (acc_sat_en && (acc_ovf || acc_sat_ovf))
            st_d.flags.second_acc_clamped_flag = 1'b1;
        end
        else
        begin
          st_d.acc_a = acc_res;
          st_d.flags.first_acc_overflow_flag = acc_res_ovf;
          if (acc_sat_en && (acc_ovf || acc_sat_ovf))
            st_d.flags.first_acc_clamped_flag = 1'b1;
        end
        st_d.flags.either_acc_overflow_flag =
          st_d.flags.first_acc_overflow_flag |
          st_d.flags.second_acc_overflow_flag;
        st_d.flags.either_acc_clamped_flag =
          st_d.flags.first_acc_clamped_flag |
          st_d.flags.second_acc_clamped_flag;
      end
      sba_pkg::OP_FILE, sba_pkg::OP_TEN_BIT_LITERAL, sba_pkg::OP_REG:
      begin
        st_d.flags.nibble_carry_flag = nib_diff[4];
        st_d.flags.negative_flag = res_neg;
        st_d.flags.signed_wrap_flag = res_ovf;
        st_d.flags.carry_flag = res_carry;
        if (!res_zero)
          st_d.flags.zero_flag = 1'b0;
        if (op == sba_pkg::OP_FILE)
        begin
          if (insn[sba_pkg::FDEST_BIT])
          begin
            st_d.mem_wr.valid = 1'b1;
            st_d.mem_wr.is_file = 1'b1;
            st_d.mem_wr.addr = {3'h0, insn[sba_pkg::FADDR_W-1:0]};
            st_d.mem_wr.data = res;
            st_d.mem_wr.byte_mode = byte_mode;
          end
          else if (byte_mode)
            st_d.regs[sba_pkg::DEFAULT_DEFAULT_WORKING_REGISTER_IDX][7:0] = res[7:0];
          else
            st_d.regs[sba_pkg::DEFAULT_DEFAULT_WORKING_REGISTER_IDX] = res;
        end
        else if (op == sba_pkg::OP_TEN_BIT_LITERAL)
        begin
          if (byte_mode)
            st_d.regs[src_idx][7:0] = res[7:0];
          else
            st_d.regs[src_idx] = res;
        end
        else
        begin
          // Source pointer update, applied first so destination wins.
          if (!five_bit_literal_form)
          begin
            case (src_mode)
              sba_pkg::AM_POSTINC, sba_pkg::AM_PREINC:
                st_d.regs[src_idx] = src_ptr + step;
              sba_pkg::AM_POSTDEC, sba_pkg::AM_PREDEC:
                st_d.regs[src_idx] = src_ptr - step;
              default:
                st_d.regs[src_idx] = st_d.regs[src_idx];
            endcase
          end
          case (dst_mode)
            sba_pkg::AM_DIRECT:
            begin
              if (byte_mode)
                st_d.regs[dst_idx][7:0] = res[7:0];
              else
                st_d.regs[dst_idx] = res;
            end
            default:
            begin
              st_d.mem_wr.valid = 1'b1;
              st_d.mem_wr.data = res;
              st_d.mem_wr.byte_mode = byte_mode;
              if (dst_mode == sba_pkg::AM_PREINC)
                st_d.mem_wr.addr = dst_ptr + step;
              else if (dst_mode == sba_pkg::AM_PREDEC)
                st_d.mem_wr.addr = dst_ptr - step;
              else
                st_d.mem_wr.addr = dst_ptr;
              if (dst_mode == sba_pkg::AM_POSTINC ||
                  dst_mode == sba_pkg::AM_PREINC)
                st_d.regs[dst_idx] = dst_ptr + step;
              else if (dst_mode == sba_pkg::AM_POSTDEC ||
                       dst_mode == sba_pkg::AM_PREDEC)
                st_d.regs[dst_idx] = dst_ptr - step;
            end
          endcase
        end
      end
      default:
        st_d.mem_wr = '0;
    endcase
    // A load from the core wins over a subtract to the same accumulator.
    if (acc_load.valid)
    begin
      if (acc_load.sel)
        st_d.acc_b = acc_load.data;
      else
        st_d.acc_a = acc_load.data;
    end
  end

  // Every instruction retires in the cycle it is presented.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q.acc_a <= sba_pkg::ACC_ZERO;
      st_q.acc_b <= sba_pkg::ACC_ZERO;
      st_q.regs <= '0;
      st_q.flags <= sba_pkg::FLAGS_RESET;
      st_q.mem_wr <= '0;
      st_q.illegal <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  assign first_accumulator = st_q.acc_a;
  assign second_accumulator = st_q.acc_b;
  assign reg_file = st_q.regs;
  assign flags = st_q.flags;
  assign mem_wr = st_q.mem_wr;
  assign illegal_op = st_q.illegal;

endmodule // sba_alu

`default_nettype wire

//--- core/sba_pkg.sv
// Package for the subtract-with-borrow datapath: encodings, field positions,
// flag layout and the operand carriers shared with the testbench.
// Assumes a 24-bit instruction word presented with a one-cycle valid strobe.
package sba_pkg;

  localparam int INSN_W = 24;
  localparam int WORD_W = 16;
  localparam int ACC_W = 40;
  localparam int FADDR_W = 13;
  localparam int REGS = 16;

  // Opcode prefixes.
  localparam logic [11:0] ACC_SUB_CODE = 12'hcb3;
  localparam logic [8:0] FILE_FORM_CODE = 9'h16b;
  localparam logic [8:0] TEN_BIT_LITERAL_FORM_CODE = 9'h163;
  localparam logic [4:0] REG_FORM_CODE = 5'h0b;
  localparam logic [1:0] FIVE_BIT_LITERAL_MARK = 2'h3;

  // Field positions.
  localparam int ACC_SEL_BIT = 15;
  localparam int BYTE_BIT = 14;
  localparam int FDEST_BIT = 13;
  localparam int BASE_LSB = 15;
  localparam int DMODE_LSB = 11;
  localparam int DREG_LSB = 7;
  localparam int SMODE_LSB = 4;
  localparam int FIVE_BIT_LITERAL_MARK_LSB = 5;
  localparam int TEN_BIT_LITERAL_LSB = 4;

  // Addressing modes of a three-bit mode field.
  localparam logic [2:0] AM_DIRECT = 3'h0;
  localparam logic [2:0] AM_IND = 3'h1;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_PREINC = 3'h5;

  // Default working register index.
  localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REGISTER_IDX = 4'h0;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ACC_W-1:0] ACC_ZERO = 40'h00_0000_0000;
  localparam logic [ACC_W-1:0] ACC_MAX_POS = 40'h00_7fff_ffff;
  localparam logic [ACC_W-1:0] ACC_MAX_NEG = 40'hff_8000_0000;

  typedef struct packed {
    logic first_acc_overflow_flag;
    logic second_acc_overflow_flag;
    logic first_acc_clamped_flag;
    logic second_acc_clamped_flag;
    logic either_acc_overflow_flag;
    logic either_acc_clamped_flag;
    logic nibble_carry_flag;
    logic negative_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic carry_flag;
  } sba_flags_t;

  localparam sba_flags_t FLAGS_RESET = '0;

  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_ACC = 5'b00010,
    OP_FILE = 5'b00100,
    OP_TEN_BIT_LITERAL = 5'b01000,
    OP_REG = 5'b10000
  } sba_op_t;

  // Memory write request for file and indirect destinations.
  typedef struct packed {
    logic valid;
    logic is_file;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] data;
    logic byte_mode;
  } sba_mem_wr_t;

  // Accumulator load from the core; sel high picks the second accumulator.
  typedef struct packed {
    logic valid;
    logic sel;
    logic [ACC_W-1:0] data;
  } sba_acc_load_t;

endpackage : sba_pkg

//--- test/sba_alu_properties.sv
// Checker for the subtract-with-borrow datapath, bound to sba_alu.
// Assumes one sys_clk domain and rst synchronous, active high.
`timescale 1ns/1ns
`default_nettype none
module sba_alu_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [sba_pkg::INSN_W-1:0] insn,
  input wire sba_pkg::sba_acc_load_t acc_load,
  input wire logic [sba_pkg::ACC_W-1:0] first_accumulator,
  input wire logic [sba_pkg::ACC_W-1:0] second_accumulator,
  input wire logic [sba_pkg::WORD_W*sba_pkg::REGS-1:0] reg_file,
  input wire sba_pkg::sba_flags_t flags,
  input wire sba_pkg::sba_mem_wr_t mem_wr,
  input wire logic illegal_op
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic acc_op;
  logic file_op;
  logic ten_bit_literal_op;
  assign acc_op = insn_valid && insn[23:16] == 8'hcb
    && insn[14:0] == 15'h3000;
  assign file_op = insn_valid && insn[23:15] == sba_pkg::FILE_FORM_CODE;
  assign ten_bit_literal_op = insn_valid && insn[23:15] == sba_pkg::TEN_BIT_LITERAL_FORM_CODE;
  sequence s_file_take;
    file_op && insn[13];
  endsequence
  sequence s_file_write;
    mem_wr.valid && mem_wr.is_file;
  endsequence
  property p_zero_sticky;
    !flags.zero_flag |=> !flags.zero_flag;
  endproperty
  a_zero_sticky: assert property (p_zero_sticky)
    else $error("zero flag was set");
  property p_file_dest;
    s_file_take |=> s_file_write ##0 (mem_wr.addr == {3'h0,
      $past(insn[12:0])} && mem_wr.byte_mode == $past(insn[14]));
  endproperty
  a_file_dest: assert property (p_file_dest)
    else $error("file destination write wrong");
  property p_file_default_working_register;
    file_op && !insn[13] |=> !mem_wr.valid && $stable(reg_file[255:16]);
  endproperty
  a_file_default_working_register: assert property (p_file_default_working_register)
    else $error("working register destination wrong");
  property p_ten_bit_literal_direct;
    ten_bit_literal_op |=> !mem_wr.valid;
  endproperty
  a_ten_bit_literal_direct: assert property (p_ten_bit_literal_direct)
    else $error("literal form touched memory");
  property p_acc_int_flags;
    acc_op |=> $stable(flags[4:0]) && $stable(reg_file);
  endproperty
  a_acc_int_flags: assert property (p_acc_int_flags)
    else $error("accumulator subtract changed integer state");
  property p_acc_first;
    acc_op && !insn[15] && !acc_load.valid |=> $stable(second_accumulator);
  endproperty
  a_acc_first: assert property (p_acc_first)
    else $error("other accumulator changed");
  property p_acc_second;
    acc_op && insn[15] && !acc_load.valid |=> $stable(first_accumulator);
  endproperty
  a_acc_second: assert property (p_acc_second)
    else $error("other accumulator changed");
  property p_refused;
    illegal_op |-> $past(insn_valid) && $stable(reg_file) && $stable(flags);
  endproperty
  a_refused: assert property (p_refused)
    else $error("unknown encoding changed state");
  property p_idle_hold;
    !insn_valid |=> $stable(reg_file) && $stable(flags)
      && !mem_wr.valid && !illegal_op;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("state changed without an instruction");
endmodule // sba_alu_properties
bind sba_alu sba_alu_properties sba_alu_properties_inst (
  .sys_clk(sys_clk),
  .rst(rst),
  .insn_valid(insn_valid),
  .insn(insn),
  .acc_load(acc_load),
  .first_accumulator(first_accumulator),
  .second_accumulator(second_accumulator),
  .reg_file(reg_file),
  .flags(flags),
  .mem_wr(mem_wr),
  .illegal_op(illegal_op)
);
`default_nettype wire

//--- test/tb_subtract_borrow_alu.sv
// Self-checking bench for the subtract-with-borrow datapath.
// Assumes sba_pkg and sba_alu are compiled first; one 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_subtract_borrow_alu;
  localparam logic [8:0] L10 = sba_pkg::TEN_BIT_LITERAL_FORM_CODE;
  localparam logic [8:0] FF = sba_pkg::FILE_FORM_CODE;
  localparam logic [4:0] RG = sba_pkg::REG_FORM_CODE;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic [23:0] insn = 24'h000000;
  logic [15:0] file_data = 16'h0000;
  logic [15:0] src_mem_data = 16'h0000;
  logic first_acc_clamp_enable = 1'b0;
  logic second_acc_clamp_enable = 1'b0;
  sba_pkg::sba_acc_load_t acc_load = '0;
  logic [39:0] first_accumulator;
  logic [39:0] second_accumulator;
  logic [255:0] reg_file;
  sba_pkg::sba_flags_t flags;
  sba_pkg::sba_mem_wr_t mem_wr;
  logic illegal_op;
  int err_total = 0;
  int checks = 0;
  always #5 sys_clk = ~sys_clk;
  sba_alu sba_alu_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .insn_valid(insn_valid),
    .insn(insn),
    .file_data(file_data),
    .src_mem_data(src_mem_data),
    .first_acc_clamp_enable(first_acc_clamp_enable),
    .second_acc_clamp_enable(second_acc_clamp_enable),
    .acc_load(acc_load),
    .first_accumulator(first_accumulator),
    .second_accumulator(second_accumulator),
    .reg_file(reg_file),
    .flags(flags),
    .mem_wr(mem_wr),
    .illegal_op(illegal_op)
  );
  function automatic logic [15:0] w(input int i);
    return reg_file[16*i +: 16];
  endfunction
  // Integer flags packed as {nibble carry, negative, wrap, zero, carry}.
  function automatic logic [15:0] fl();
    return {11'h000, flags[4:0]};
  endfunction
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [23:0] i,
    input logic [15:0] fd = 16'h0000, input logic [15:0] sd = 16'h0000);
    insn_valid <= 1'b1;
    insn <= i;
    file_data <= fd;
    src_mem_data <= sd;
    @(posedge sys_clk);
  endtask
  task automatic ck_acc(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Loads one accumulator; the caller drops the strobe after the last load.
  task automatic load(input logic second, input logic [39:0] d);
    acc_load <= {1'b1, second, d};
    @(posedge sys_clk);
  endtask
  task automatic settle();
    insn_valid <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Carry starts clear, so the first subtract borrows one extra.
  task automatic t_ten_bit_literal();
    run({L10, 1'b0, 10'h000, 4'h1});
    run({L10, 1'b0, 10'h3ff, 4'h1});
    settle();
    ck(w(1), 16'hfbff);
    ck(fl(), 16'h0009);
    @(posedge sys_clk);
    run({L10, 1'b1, 10'h0ff, 4'h1});
    settle();
    ck(w(1), 16'hfb00);
    ck(fl(), 16'h0011);
    @(posedge sys_clk);
  endtask
  task automatic t_file();
    run({FF, 1'b0, 1'b0, 13'h0a04}, 16'h1234);
    settle();
    ck(w(0), 16'h1234);
    ck({15'h0000, mem_wr.valid}, 16'h0000);
    ck(fl(), 16'h0011);
    @(posedge sys_clk);
    run({FF, 1'b0, 1'b1, 13'h1fff}, 16'h1000);
    settle();
    ck(mem_wr.data, 16'hfdcc);
    ck(mem_wr.addr, 16'h1fff);
    ck({14'h0000, mem_wr.valid, mem_wr.is_file}, 16'h0003);
    ck(w(0), 16'h1234);
    ck(fl(), 16'h0008);
    @(posedge sys_clk);
  endtask
  task automatic t_reg();
    run({RG, 4'h0, 1'b0, 3'h0, 4'h2, 2'h3, 5'h1f});
    settle();
    ck(w(2), 16'h1214);
    ck(fl(), 16'h0001);
    @(posedge sys_clk);
    run({RG, 4'h1, 1'b0, 3'h0, 4'h3, 3'h0, 4'h0});
    settle();
    ck(w(3), 16'he8cc);
    ck(fl(), 16'h0009);
    @(posedge sys_clk);
    run({RG, 4'h0, 1'b0, 3'h0, 4'h3, 3'h3, 4'h2}, 16'h0000, 16'h0004);
    settle();
    ck(w(3), 16'h1230);
    ck(w(2), 16'h1216);
    ck(fl(), 16'h0011);
    @(posedge sys_clk);
    run({RG, 4'h0, 1'b0, 3'h1, 4'h2, 3'h0, 4'h0});
    settle();
    ck(mem_wr.addr, 16'h1216);
    ck(mem_wr.data, 16'h0000);
    ck(fl(), 16'h0011);
    @(posedge sys_clk);
  endtask
  task automatic t_acc();
    load(1'b0, 40'h76_120f_098a);
    load(1'b1, 40'h23_f312_bc17);
    acc_load <= '0;
    run({8'hcb, 1'b0, 3'h3, 12'h000});
    settle();
    ck_acc(first_accumulator, 40'h52_1efc_4d73);
    ck_acc(second_accumulator, 40'h23_f312_bc17);
    ck({5'h00, flags}, 16'h0451);
    @(posedge sys_clk);
    load(1'b0, 40'hff_9022_2ee1);
    load(1'b1, 40'h00_2456_8f4c);
    acc_load <= '0;
    second_acc_clamp_enable <= 1'b1;
    run({8'hcb, 1'b1, 3'h3, 12'h000});
    settle();
    ck_acc(second_accumulator, 40'h00_7fff_ffff);
    ck_acc(first_accumulator, 40'hff_9022_2ee1);
    ck({5'h00, flags}, 16'h04f1);
    ck(w(3), 16'h1230);
    @(posedge sys_clk);
    first_acc_clamp_enable <= 1'b1;
    run({8'hcb, 1'b0, 3'h3, 12'h000});
    settle();
    ck_acc(first_accumulator, 40'hff_8000_0000);
    ck({5'h00, flags}, 16'h01b1);
    @(posedge sys_clk);
  endtask
  task automatic t_bad();
    run(24'hffffff);
    settle();
    ck({15'h0000, illegal_op}, 16'h0001);
    ck({5'h00, flags}, 16'h01b1);
    ck(w(1), 16'hfb00);
    @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_ten_bit_literal();
    t_file();
    t_reg();
    t_acc();
    t_bad();
    close_out();
  end
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule // tb_subtract_borrow_alu
`default_nettype wire
